// ===== rtl/dpll_output_freq_bw_config.sv
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Codes 000 and 001 give 311.04 MHz; 000 digital, 001 analog feedback, resets 001.
// - Code 010 gives twelve-E1 mode, 98.304 MHz analog PLL output.
// - Code 011 gives sixteen-E1 mode, 131.072 MHz analog PLL output.
// - Code 100 gives twenty-four-DS1 mode, 148.224 MHz analog PLL output.
// - Code 101 gives sixteen-DS1 mode, 98.816 MHz analog PLL output.
// - Main digital PLL rate stays 77.76 MHz whatever the field holds.
// - The 3-bit field sets the frequency fed to the main analog PLL.
// - Aux bandwidth code 00, 01, 10 gives 18, 35, 70 Hz; 11 unused.
// - Aux bandwidth register resets to zero; bits 7 to 2 read zero.
module dpll_output_freq_bw_config
  import dpll_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         srst_in,
  // AXI4-Lite write address
  input  wire logic         axi_awvalid_in,
  output logic              axi_awready_out,
  input  wire logic [11:0]  axi_awaddr_in,
  // AXI4-Lite write data
  input  wire logic         axi_wvalid_in,
  output logic              axi_wready_out,
  input  wire logic [31:0]  axi_wdata_in,
  input  wire logic [3:0]   axi_wstrb_in,
  // AXI4-Lite write response
  output logic              axi_bvalid_out,
  input  wire logic         axi_bready_in,
  output logic [1:0]        axi_bresp_out,
  // AXI4-Lite read address
  input  wire logic         axi_arvalid_in,
  output logic              axi_arready_out,
  input  wire logic [11:0]  axi_araddr_in,
  // AXI4-Lite read data
  output logic              axi_rvalid_out,
  input  wire logic         axi_rready_in,
  output logic [31:0]       axi_rdata_out,
  output logic [1:0]        axi_rresp_out,
  // Main path setting
  output logic              main_feedback_analog_out,
  output logic [18:0]       main_analog_pll_khz_out,
  output logic [18:0]       main_digital_pll_khz_out,
  // Aux path setting
  output logic [6:0]        aux_loop_bandwidth_hz_out,
  // Unused code held in a field
  output logic              unused_code_out
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic         awready;
    logic [11:0]  aw_addr;
    logic         wready;
    logic [7:0]   w_data;
    logic         w_lane0;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         arready;
    logic         rvalid;
    logic [7:0]   rdata;
    logic [1:0]   rresp;
    logic [2:0]   main_output_multiplier_select;
    logic [1:0]   aux_loop_bandwidth_select;
    logic         fb_analog;
    logic [18:0]  apll_khz;
    logic [18:0]  dpll_khz;
    logic [6:0]   bw_hz;
    logic         bad_code;
  } cfg_state_s;

  localparam cfg_state_s STATE_RESET = '{
    awready:                       1'b1,
    aw_addr:                       12'h000,
    wready:                        1'b1,
    w_data:                        8'h00,
    w_lane0:                       1'b0,
    bvalid:                        1'b0,
    bresp:                         RESP_OKAY,
    arready:                       1'b1,
    rvalid:                        1'b0,
    rdata:                         8'h00,
    rresp:                         RESP_OKAY,
    main_output_multiplier_select: MAIN_FREQ_RESET,
    aux_loop_bandwidth_select:     AUX_BW_RESET,
    fb_analog:                     1'b1,
    apll_khz:                      KHZ_311_04,
    dpll_khz:                      KHZ_DPLL_FIXED,
    bw_hz:                         HZ_BW_18,
    bad_code:                      1'b0
  };

  cfg_state_s  st;
  cfg_state_s  next_st;
  logic        wr_fire;
  logic        rd_fire;
  logic        main_ok;
  logic        main_fb;
  logic [18:0] main_khz;
  logic        aux_ok;
  logic [6:0]  aux_hz;

  // ****************************************
  // Lookups
  // ****************************************
  main_freq_lookup u_main_lookup (
    .code_in       (st.main_output_multiplier_select),
    .valid_out     (main_ok),
    .analog_fb_out (main_fb),
    .apll_khz_out  (main_khz)
  );

  aux_bw_lookup u_aux_lookup (
    .code_in   (st.aux_loop_bandwidth_select),
    .valid_out (aux_ok),
    .bw_hz_out (aux_hz)
  );

  assign wr_fire = !st.awready && !st.wready && !st.bvalid;
  assign rd_fire = axi_arvalid_in && st.arready;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    // Write channels taken in either order
    if (axi_awvalid_in && st.awready) begin
      next_st.awready = 1'b0;
      next_st.aw_addr = axi_awaddr_in;
    end
    if (axi_wvalid_in && st.wready) begin
      next_st.wready  = 1'b0;
      next_st.w_data  = axi_wdata_in[7:0];
      next_st.w_lane0 = axi_wstrb_in[0];
    end
    // Register write
    if (wr_fire) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = RESP_OKAY;
      if (st.aw_addr == ADDR_MAIN_FREQ) begin
        if (st.w_lane0) begin
          next_st.main_output_multiplier_select =
            st.w_data[MAIN_FREQ_LSB +: MAIN_FREQ_W];
        end
      end else if (st.aw_addr == ADDR_AUX_BW) begin
        if (st.w_lane0) begin
          next_st.aux_loop_bandwidth_select = st.w_data[AUX_BW_LSB +: AUX_BW_W];
        end
      end else begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && axi_bready_in) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end
    // Register read
    if (rd_fire) begin
      next_st.arready = 1'b0;
      next_st.rvalid  = 1'b1;
      next_st.rresp   = RESP_OKAY;
      if (axi_araddr_in == ADDR_MAIN_FREQ) begin
        next_st.rdata = {5'h00, st.main_output_multiplier_select};
      end else if (axi_araddr_in == ADDR_AUX_BW) begin
        next_st.rdata = {6'h00, st.aux_loop_bandwidth_select};
      end else begin
        next_st.rdata = 8'h00;
        next_st.rresp = RESP_SLVERR;
      end
    end
    if (st.rvalid && axi_rready_in) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
    // Decoded settings, last good one kept on unused codes
    if (main_ok) begin
      next_st.fb_analog = main_fb;
      next_st.apll_khz  = main_khz;
    end
    if (aux_ok) begin
      next_st.bw_hz = aux_hz;
    end
    next_st.bad_code = !main_ok || !aux_ok;
    next_st.dpll_khz = KHZ_DPLL_FIXED;
    if (srst_in) begin
      next_st = STATE_RESET;
    end
  end

  always_ff @(posedge core_clk_in) begin
    st <= next_st;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign axi_awready_out           = st.awready;
  assign axi_wready_out            = st.wready;
  assign axi_bvalid_out            = st.bvalid;
  assign axi_bresp_out             = st.bresp;
  assign axi_arready_out           = st.arready;
  assign axi_rvalid_out            = st.rvalid;
  assign axi_rdata_out             = {24'h000000, st.rdata};
  assign axi_rresp_out             = st.rresp;
  assign main_feedback_analog_out  = st.fb_analog;
  assign main_analog_pll_khz_out   = st.apll_khz;
  assign main_digital_pll_khz_out  = st.dpll_khz;
  assign aux_loop_bandwidth_hz_out = st.bw_hz;
  assign unused_code_out           = st.bad_code;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_code_held(logic [2:0] c);
    st.main_output_multiplier_select == c ##1 st.main_output_multiplier_select == c;
  endsequence

  property p_code_311_digital;
    s_code_held(CODE_311_DIGITAL) |-> st.apll_khz == KHZ_311_04 && !st.fb_analog;
  endproperty
  a_code_311_digital: assert property (p_code_311_digital)
    else $error("code 000 not 311.04 MHz digital feedback");

  property p_code_311_analog;
    s_code_held(CODE_311_ANALOG) |-> st.apll_khz == KHZ_311_04 && st.fb_analog;
  endproperty
  a_code_311_analog: assert property (p_code_311_analog)
    else $error("code 001 not 311.04 MHz analog feedback");

  property p_code_12e1;
    s_code_held(CODE_12E1) |-> st.apll_khz == KHZ_98_304;
  endproperty
  a_code_12e1: assert property (p_code_12e1)
    else $error("code 010 not 98.304 MHz");

  property p_code_16e1;
    s_code_held(CODE_16E1) |-> st.apll_khz == KHZ_131_072;
  endproperty
  a_code_16e1: assert property (p_code_16e1)
    else $error("code 011 not 131.072 MHz");

  property p_code_24ds1;
    s_code_held(CODE_24DS1) |-> st.apll_khz == KHZ_148_224;
  endproperty
  a_code_24ds1: assert property (p_code_24ds1)
    else $error("code 100 not 148.224 MHz");

  property p_code_16ds1;
    s_code_held(CODE_16DS1) |-> st.apll_khz == KHZ_98_816;
  endproperty
  a_code_16ds1: assert property (p_code_16ds1)
    else $error("code 101 not 98.816 MHz");

  property p_dpll_fixed;
    $changed(st.main_output_multiplier_select) |-> ##[1:2] st.dpll_khz == KHZ_DPLL_FIXED;
  endproperty
  a_dpll_fixed: assert property (p_dpll_fixed)
    else $error("main digital PLL rate moved");

  sequence s_main_write;
    wr_fire && st.aw_addr == ADDR_MAIN_FREQ && st.w_lane0;
  endsequence

  property p_main_write;
    s_main_write |=> st.main_output_multiplier_select == $past(st.w_data[2:0])
                     ##0 st.bvalid && st.bresp == RESP_OKAY;
  endproperty
  a_main_write: assert property (p_main_write)
    else $error("main frequency write not applied");

  property p_aux_bw;
    st.aux_loop_bandwidth_select == CODE_BW_70 ##1 st.aux_loop_bandwidth_select == CODE_BW_70
      |-> st.bw_hz == HZ_BW_70;
  endproperty
  a_aux_bw: assert property (p_aux_bw)
    else $error("code 10 not 70 Hz");

  property p_aux_read;
    rd_fire && axi_araddr_in == ADDR_AUX_BW
      |=> st.rvalid && st.rdata == {6'h00, $past(st.aux_loop_bandwidth_select)};
  endproperty
  a_aux_read: assert property (p_aux_read)
    else $error("aux bandwidth read wrong or upper bits set");

  property p_bresp_hold;
    st.bvalid && !axi_bready_in |=> st.bvalid && $stable(st.bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold)
    else $error("write response dropped before taken");

endmodule

`default_nettype wire

// ===== rtl/dpll_cfg_pkg.sv
package dpll_cfg_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam int           ADDR_W             = 12;
  localparam logic [7:0]   REG_IDX_MAIN_FREQ  = 8'h65;
  localparam logic [7:0]   REG_IDX_AUX_BW     = 8'h66;
  localparam logic [11:0]  ADDR_MAIN_FREQ     = {2'h0, REG_IDX_MAIN_FREQ, 2'h0};
  localparam logic [11:0]  ADDR_AUX_BW        = {2'h0, REG_IDX_AUX_BW, 2'h0};

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int           MAIN_FREQ_LSB      = 0;
  localparam int           MAIN_FREQ_W        = 3;
  localparam int           AUX_BW_LSB         = 0;
  localparam int           AUX_BW_W           = 2;
  localparam logic [2:0]   MAIN_FREQ_RESET    = 3'h1;
  localparam logic [1:0]   AUX_BW_RESET       = 2'h0;

  // ****************************************
  // Main-path multiplier codes
  // ****************************************
  localparam logic [2:0]   CODE_311_DIGITAL   = 3'h0;
  localparam logic [2:0]   CODE_311_ANALOG    = 3'h1;
  localparam logic [2:0]   CODE_12E1          = 3'h2;
  localparam logic [2:0]   CODE_16E1          = 3'h3;
  localparam logic [2:0]   CODE_24DS1         = 3'h4;
  localparam logic [2:0]   CODE_16DS1         = 3'h5;

  // ****************************************
  // Frequencies in kHz
  // ****************************************
  localparam int           KHZ_W              = 19;
  localparam logic [18:0]  KHZ_311_04         = 19'h4BF00;
  localparam logic [18:0]  KHZ_98_304         = 19'h18000;
  localparam logic [18:0]  KHZ_131_072        = 19'h20000;
  localparam logic [18:0]  KHZ_148_224        = 19'h24300;
  localparam logic [18:0]  KHZ_98_816         = 19'h18200;
  localparam logic [18:0]  KHZ_DPLL_FIXED     = 19'h12FC0;

  // ****************************************
  // Auxiliary bandwidth codes and values
  // ****************************************
  localparam logic [1:0]   CODE_BW_18         = 2'h0;
  localparam logic [1:0]   CODE_BW_35         = 2'h1;
  localparam logic [1:0]   CODE_BW_70         = 2'h2;
  localparam logic [6:0]   HZ_BW_18           = 7'h12;
  localparam logic [6:0]   HZ_BW_35           = 7'h23;
  localparam logic [6:0]   HZ_BW_70           = 7'h46;

  // ****************************************
  // AXI responses
  // ****************************************
  localparam logic [1:0]   RESP_OKAY          = 2'h0;
  localparam logic [1:0]   RESP_SLVERR        = 2'h2;

endpackage

// ===== rtl/main_freq_lookup.sv
`timescale 1ns/100ps
`default_nettype none

module main_freq_lookup
  import dpll_cfg_pkg::*;
(
  // Code in
  input  wire logic [2:0]  code_in,
  // Decoded setting
  output logic             valid_out,
  output logic             analog_fb_out,
  output logic [18:0]      apll_khz_out
);

  always_comb begin
    valid_out     = 1'b1;
    analog_fb_out = 1'b0;
    apll_khz_out  = KHZ_311_04;
    case (code_in)
      CODE_311_DIGITAL: begin
        apll_khz_out = KHZ_311_04;
      end
      CODE_311_ANALOG: begin
        analog_fb_out = 1'b1;
        apll_khz_out  = KHZ_311_04;
      end
      CODE_12E1: begin
        apll_khz_out = KHZ_98_304;
      end
      CODE_16E1: begin
        apll_khz_out = KHZ_131_072;
      end
      CODE_24DS1: begin
        apll_khz_out = KHZ_148_224;
      end
      CODE_16DS1: begin
        apll_khz_out = KHZ_98_816;
      end
      default: begin
        valid_out = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== rtl/aux_bw_lookup.sv
`timescale 1ns/100ps
`default_nettype none

module aux_bw_lookup
  import dpll_cfg_pkg::*;
(
  // Code in
  input  wire logic [1:0]  code_in,
  // Decoded bandwidth
  output logic             valid_out,
  output logic [6:0]       bw_hz_out
);

  always_comb begin
    valid_out = 1'b1;
    bw_hz_out = HZ_BW_18;
    case (code_in)
      CODE_BW_18: begin
        bw_hz_out = HZ_BW_18;
      end
      CODE_BW_35: begin
        bw_hz_out = HZ_BW_35;
      end
      CODE_BW_70: begin
        bw_hz_out = HZ_BW_70;
      end
      default: begin
        valid_out = 1'b0;
      end
    endcase
  end

endmodule

`default_nettype wire

// ===== rtl/_unused_guard.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  import dpll_cfg_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  data;
    logic [7:0]  rd;
    logic [18:0] khz;
    logic        fb;
    logic [6:0]  hz;
  } row_s;

  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        awvalid = 1'b0;
  logic [11:0] awaddr  = 12'h000;
  logic        wvalid  = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic [11:0] araddr  = 12'h000;
  logic        rready  = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, fb, unused;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [18:0] apll, dpll;
  logic [6:0]  bw;
  int          n_mismatch  = 0;
  int          check_count = 0;
  row_s        rows [9];

  always #5 clk = ~clk;

  dpll_output_freq_bw_config u_dut (
    .core_clk_in              (clk),
    .srst_in                  (srst),
    .axi_awvalid_in           (awvalid),
    .axi_awready_out          (awready),
    .axi_awaddr_in            (awaddr),
    .axi_wvalid_in            (wvalid),
    .axi_wready_out           (wready),
    .axi_wdata_in             (wdata),
    .axi_wstrb_in             (wstrb),
    .axi_bvalid_out           (bvalid),
    .axi_bready_in            (bready),
    .axi_bresp_out            (bresp),
    .axi_arvalid_in           (arvalid),
    .axi_arready_out          (arready),
    .axi_araddr_in            (araddr),
    .axi_rvalid_out           (rvalid),
    .axi_rready_in            (rready),
    .axi_rdata_out            (rdata),
    .axi_rresp_out            (rresp),
    .main_feedback_analog_out (fb),
    .main_analog_pll_khz_out  (apll),
    .main_digital_pll_khz_out (dpll),
    .aux_loop_bandwidth_hz_out(bw),
    .unused_code_out          (unused)
  );

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    logic done;
    done = 1'b0;
    awaddr  <= a;
    wdata   <= {24'h0, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && !awvalid && !wvalid) begin
        resp = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic axi_read(input logic [11:0] a);
    logic done;
    done = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && !arvalid) begin
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input logic [1:0] r);
    axi_read(a);
    check(rd, {24'h0, exp});
    check(32'(resp), 32'(r));
  endtask

  task automatic out_chk(input logic [18:0] k, input logic f, input logic [6:0] h,
                         input logic u);
    check(32'(apll), 32'(k));
    check(32'(fb), 32'(f));
    check(32'(bw), 32'(h));
    check(32'(dpll), 32'(KHZ_DPLL_FIXED));
    check(32'(unused), 32'(u));
  endtask

  task automatic reset_chk(input string name);
    check(32'({awready, wready, arready, bvalid, rvalid}), 32'h1C);
    out_chk(KHZ_311_04, 1'b1, HZ_BW_18, 1'b0);
    rd_chk(ADDR_MAIN_FREQ, 8'h01, RESP_OKAY);
    rd_chk(ADDR_AUX_BW, 8'h00, RESP_OKAY);
    $display("test %s done", name);
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    close_out();
  end

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rows[0] = '{ADDR_MAIN_FREQ, 8'h00, 8'h00, KHZ_311_04, 1'b0, HZ_BW_18};
    rows[1] = '{ADDR_MAIN_FREQ, 8'h02, 8'h02, KHZ_98_304, 1'b0, HZ_BW_18};
    rows[2] = '{ADDR_MAIN_FREQ, 8'h03, 8'h03, KHZ_131_072, 1'b0, HZ_BW_18};
    rows[3] = '{ADDR_MAIN_FREQ, 8'h04, 8'h04, KHZ_148_224, 1'b0, HZ_BW_18};
    rows[4] = '{ADDR_MAIN_FREQ, 8'hFD, 8'h05, KHZ_98_816, 1'b0, HZ_BW_18};
    rows[5] = '{ADDR_MAIN_FREQ, 8'h01, 8'h01, KHZ_311_04, 1'b1, HZ_BW_18};
    rows[6] = '{ADDR_AUX_BW, 8'h01, 8'h01, KHZ_311_04, 1'b1, HZ_BW_35};
    rows[7] = '{ADDR_AUX_BW, 8'hFE, 8'h02, KHZ_311_04, 1'b1, HZ_BW_70};
    rows[8] = '{ADDR_AUX_BW, 8'h00, 8'h00, KHZ_311_04, 1'b1, HZ_BW_18};
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    reset_chk("reset");
    for (int i = 0; i < 9; i++) begin
      axi_write(rows[i].addr, rows[i].data, 4'hF);
      check(32'(resp), 32'(RESP_OKAY));
      rd_chk(rows[i].addr, rows[i].rd, RESP_OKAY);
      out_chk(rows[i].khz, rows[i].fb, rows[i].hz, 1'b0);
    end
    $display("test rows done");
    axi_write(ADDR_AUX_BW + 12'h004, 8'h05, 4'hF);
    check(32'(resp), 32'(RESP_SLVERR));
    rd_chk(ADDR_AUX_BW + 12'h004, 8'h00, RESP_SLVERR);
    axi_write(ADDR_MAIN_FREQ, 8'h03, 4'h0);
    check(32'(resp), 32'(RESP_OKAY));
    rd_chk(ADDR_MAIN_FREQ, 8'h01, RESP_OKAY);
    $display("test unmapped and strobe done");
    axi_write(ADDR_MAIN_FREQ, 8'h06, 4'hF);
    rd_chk(ADDR_MAIN_FREQ, 8'h06, RESP_OKAY);
    out_chk(KHZ_311_04, 1'b1, HZ_BW_18, 1'b1);
    axi_write(ADDR_AUX_BW, 8'h03, 4'hF);
    rd_chk(ADDR_AUX_BW, 8'h03, RESP_OKAY);
    axi_write(ADDR_MAIN_FREQ, 8'h07, 4'hF);
    rd_chk(ADDR_MAIN_FREQ, 8'h07, RESP_OKAY);
    out_chk(KHZ_311_04, 1'b1, HZ_BW_18, 1'b1);
    axi_write(ADDR_MAIN_FREQ, 8'h04, 4'hF);
    out_chk(KHZ_148_224, 1'b0, HZ_BW_18, 1'b1);
    axi_write(ADDR_AUX_BW, 8'h01, 4'hF);
    out_chk(KHZ_148_224, 1'b0, HZ_BW_35, 1'b0);
    $display("test unused codes done");
    awaddr  <= ADDR_AUX_BW;
    wdata   <= 32'h00000002;
    wstrb   <= 4'hF;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
    end while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(bvalid), 32'h1);
    check(32'(bresp), 32'(RESP_OKAY));
    bready <= 1'b1;
    do begin
      @(posedge clk);
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge clk);
    check(32'(bvalid), 32'h0);
    out_chk(KHZ_148_224, 1'b0, HZ_BW_70, 1'b0);
    $display("test response hold done");
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    reset_chk("second reset");
    close_out();
  end

endmodule

`default_nettype wire
